//--- rtl/dlt_device.sv
// Summary of operation
// R1: Ready high when a line accepts triggers
// R2: Live view forces ready low, triggers accepted
// R3: Controller uses busy during live view
// R4: Line 0 busy while measuring or switching
// R5: Controller waits for line 0 busy
// R6: Line 1 busy pin shows run otherwise
// R7: Line 1 busy in dual mode; controller waits
// R8: Judgement and data update at busy fall
// R9: Setting selects pass or fail polarity
// R10: Gate pulses for configured duration
// R11: Output time shorter than trigger interval
// R12: Gate only when output step present
// R13: Output starts at output step, busy maybe high
// R14: Judgement and gate not simultaneous
// R15: Lines triggered independently, any order
// R16: One measurement per rising trigger edge
// R17: Controller holds trigger at least 0.5 ms
// R18: Trigger noise filter, default 100 us
// R19: Simultaneous triggers may delay one line
// R20: Two-stage synchroniser before filter
//
// Purpose: Device end: two measurement lines with busy, ready, judgement, gate
// Assumes: measurement is modelled by counters; result arrives on resultIn
// Notes: Line 1 capture waits while line 0 captures (shared camera)
`timescale 1ns/1ps
`include "dlt_defines.svh"
module dlt_device
	import dlt_pkg::*;
#(
	parameter int FILTER_CYC = `DLT_FILTER_CYC,
	parameter int GATE_CYC = `DLT_GATE_CYC,
	parameter int MEAS_CYC = `DLT_MEAS_CYC,
	parameter int CAPTURE_CYC = `DLT_CAPTURE_CYC,
	parameter int GATE_DELAY_CYC = `DLT_GATE_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	dlt_if.device link,
	input wire logic dualLineMode,
	input wire logic liveView,
	input wire logic judgeOnFail,
	input wire logic outputStepPresent,
	input wire logic [1:0] lineFail,
	input wire logic [15:0] resultIn,
	output logic runIndication
);
	localparam int CW = `DLT_CNT_W;
	initial begin
		if (FILTER_CYC < 1 || GATE_CYC < 1 || CAPTURE_CYC < 1 ||
			MEAS_CYC <= CAPTURE_CYC || GATE_DELAY_CYC >= MEAS_CYC - CAPTURE_CYC ||
			MEAS_CYC >= (1 << CW) || FILTER_CYC >= (1 << CW) || GATE_CYC >= (1 << CW))
			$error("dlt_device: parameter out of range");
	end

	function automatic logic judgeLevel(input logic fail, input logic onFail);
		return fail ~^ onFail;
	endfunction

	logic [1:0] syncA, syncB, filt, filtPrev;
	logic [1:0] next_filt;
	logic [CW-1:0] filtCnt [2];
	logic [CW-1:0] next_filtCnt [2];
	dlt_line_state_t st [2];
	dlt_line_state_t next_st [2];
	logic [CW-1:0] measCnt [2];
	logic [CW-1:0] next_measCnt [2];
	logic [CW-1:0] gateCnt [2];
	logic [CW-1:0] next_gateCnt [2];
	logic [1:0] busy, next_busy, ready, next_ready, judge, next_judge, gate, next_gate;
	logic [1:0] pendFail, next_pendFail;
	logic [15:0] data, next_data, pendData, next_pendData;
	logic run, next_run;
	logic [1:0] rise;

	assign rise = filt & ~filtPrev;
	assign link.lineAcceptOk = ready;
	assign link.lineWorking = busy;
	assign link.lineJudgement = judge;
	assign link.lineResultBits = data;
	assign link.lineLatchStrobe = gate;
	assign runIndication = run;

	always_comb begin
		next_filt = filt;
		next_st = st;
		next_measCnt = measCnt;
		next_gateCnt = gateCnt;
		next_busy = busy;
		next_ready = ready;
		next_judge = judge;
		next_gate = gate;
		next_pendFail = pendFail;
		next_data = data;
		next_pendData = pendData;
		next_run = 1'b1;
		next_filtCnt = filtCnt;
		for (int i = 0; i < 2; i++) begin
			// R18: noise filter
			if (syncB[i] == filt[i]) begin
				next_filtCnt[i] = '0;
			end else if (filtCnt[i] >= CW'(FILTER_CYC - 1)) begin
				next_filtCnt[i] = '0;
				next_filt[i] = syncB[i];
			end else begin
				next_filtCnt[i] = filtCnt[i] + 1'b1;
			end
			unique case (st[i])
				DLT_IDLE: begin
					// R15: R16: one start per edge
					if (rise[i]) begin
						next_st[i] = DLT_CAPTURE;
						next_measCnt[i] = '0;
						next_busy[i] = 1'b1;
					end
				end
				DLT_CAPTURE: begin
					// R19: line 1 waits for shared capture
					if (!(i == 1 && st[0] == DLT_CAPTURE)) begin
						if (measCnt[i] >= CW'(CAPTURE_CYC - 1)) begin
							next_st[i] = DLT_PROCESS;
						end
						next_measCnt[i] = measCnt[i] + 1'b1;
					end
				end
				DLT_PROCESS: begin
					next_measCnt[i] = measCnt[i] + 1'b1;
					// R13: R12: output step may precede busy fall
					if (measCnt[i] == CW'(CAPTURE_CYC + GATE_DELAY_CYC) && outputStepPresent) begin
						// R14: gate starts before judgement updates
						next_gate[i] = 1'b1;
						next_gateCnt[i] = '0;
						next_pendFail[i] = lineFail[i];
						next_pendData[i*8 +: 8] = resultIn[i*8 +: 8];
					end
					if (measCnt[i] >= CW'(MEAS_CYC - 1)) begin
						next_st[i] = DLT_IDLE;
						// R4: R7: busy ends with measurement
						next_busy[i] = 1'b0;
						// R8: R9: update at busy fall
						next_judge[i] = judgeLevel(next_pendFail[i], judgeOnFail);
						next_data[i*8 +: 8] = next_pendData[i*8 +: 8];
					end
				end
				default: next_st[i] = DLT_IDLE;
			endcase
			// R10: gate pulse length
			if (gate[i]) begin
				if (gateCnt[i] >= CW'(GATE_CYC - 1)) begin
					next_gate[i] = 1'b0;
				end else begin
					next_gateCnt[i] = gateCnt[i] + 1'b1;
				end
			end
			// R1: R2: ready when idle, low in live view
			next_ready[i] = (next_st[i] == DLT_IDLE) && !liveView;
		end
		// R6: busy 1 pin carries run outside dual mode
		if (!dualLineMode) begin
			next_busy[1] = 1'b1;
			next_st[1] = DLT_IDLE;
			next_ready[1] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			syncA <= 2'h0;
			syncB <= 2'h0;
			filt <= 2'h0;
			filtPrev <= 2'h0;
			filtCnt <= '{default: '0};
			st <= '{default: DLT_IDLE};
			measCnt <= '{default: '0};
			gateCnt <= '{default: '0};
			busy <= 2'h0;
			ready <= 2'h0;
			judge <= 2'h0;
			gate <= 2'h0;
			pendFail <= 2'h0;
			data <= 16'h0000;
			pendData <= 16'h0000;
			run <= 1'b0;
		end else begin
			// R20: two-stage synchroniser
			syncA <= link.lineTrigger;
			syncB <= syncA;
			filt <= next_filt;
			filtPrev <= filt;
			filtCnt <= next_filtCnt;
			st <= next_st;
			measCnt <= next_measCnt;
			gateCnt <= next_gateCnt;
			busy <= next_busy;
			ready <= next_ready;
			judge <= next_judge;
			gate <= next_gate;
			pendFail <= next_pendFail;
			data <= next_data;
			pendData <= next_pendData;
			run <= next_run;
		end
	end
endmodule

//--- rtl/dlt_defines.svh
// Purpose: Constants for the dual-line trigger handshake
// Assumes: sys_clk at 10 MHz
// Notes: Filter and hold times in us, counts derived; gate, measure, capture and delay given in cycles
`ifndef DLT_DEFINES_SVH
`define DLT_DEFINES_SVH
`define DLT_CLK_KHZ 10000
`define DLT_FILTER_US 100
`define DLT_FILTER_CYC ((`DLT_FILTER_US * `DLT_CLK_KHZ) / 1000)
`define DLT_TRIG_HOLD_US 500
`define DLT_TRIG_HOLD_CYC ((`DLT_TRIG_HOLD_US * `DLT_CLK_KHZ + 999) / 1000)
`define DLT_GATE_CYC 100
`define DLT_MEAS_CYC 300
`define DLT_CAPTURE_CYC 50
`define DLT_GATE_DELAY_CYC 20
`define DLT_CNT_W 16
`endif

//--- rtl/dlt_pkg.sv
// Purpose: Types for the dual-line trigger handshake
// Assumes: nothing
// Notes: Shared by both ends
package dlt_pkg;
	typedef enum logic [1:0] {DLT_IDLE, DLT_CAPTURE, DLT_PROCESS} dlt_line_state_t;
	typedef enum logic [1:0] {DLT_H_IDLE, DLT_H_HIGH, DLT_H_WAIT} dlt_host_state_t;
endpackage

//--- rtl/dlt_if.sv
// Purpose: Parallel lines between device and controller
// Assumes: one clock domain
// Notes: Index 0 and 1 are the two lines
`timescale 1ns/1ps
interface dlt_if;
	logic [1:0] lineTrigger;
	logic [1:0] lineAcceptOk;
	logic [1:0] lineWorking;
	logic [1:0] lineJudgement;
	logic [15:0] lineResultBits;
	logic [1:0] lineLatchStrobe;
	modport device (input lineTrigger, output lineAcceptOk, output lineWorking,
		output lineJudgement, output lineResultBits, output lineLatchStrobe);
	modport host (output lineTrigger, input lineAcceptOk, input lineWorking,
		input lineJudgement, input lineResultBits, input lineLatchStrobe);
endinterface

//--- rtl/dlt_host.sv
// Purpose: Controller end: fires triggers and latches results on gate
// Assumes: inputs synchronous to sys_clk
// Notes: One request per line at a time
`timescale 1ns/1ps
`include "dlt_defines.svh"
module dlt_host
	import dlt_pkg::*;
#(
	parameter int HOLD_CYC = `DLT_TRIG_HOLD_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	dlt_if.host link,
	input wire logic [1:0] fireReq,
	output logic [1:0] fireBusy,
	output logic [15:0] latchedData,
	output logic [1:0] latchedJudgement,
	output logic [1:0] latchedValid
);
	localparam int CW = `DLT_CNT_W;
	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CW))
			$error("dlt_host: parameter out of range");
	end

	dlt_host_state_t st [2];
	dlt_host_state_t next_st [2];
	logic [CW-1:0] cnt [2];
	logic [CW-1:0] next_cnt [2];
	logic [1:0] trig, next_trig, fb, next_fb, jud, next_jud, val, next_val, gatePrev;
	logic [15:0] dat, next_dat;

	assign link.lineTrigger = trig;
	assign fireBusy = fb;
	assign latchedData = dat;
	assign latchedJudgement = jud;
	assign latchedValid = val;

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_trig = trig;
		next_dat = dat;
		next_jud = jud;
		next_val = 2'h0;
		next_fb = fb;
		for (int i = 0; i < 2; i++) begin
			unique case (st[i])
				DLT_H_IDLE: begin
					// R3: R5: R7: fire only when busy low
					if (fireReq[i] && !link.lineWorking[i]) begin
						next_st[i] = DLT_H_HIGH;
						next_trig[i] = 1'b1;
						next_cnt[i] = '0;
					end
				end
				DLT_H_HIGH: begin
					// R17: hold trigger high
					if (cnt[i] >= CW'(HOLD_CYC - 1)) begin
						next_trig[i] = 1'b0;
						next_st[i] = DLT_H_WAIT;
					end else begin
						next_cnt[i] = cnt[i] + 1'b1;
					end
				end
				DLT_H_WAIT: begin
					// R11: next trigger only after busy falls
					if (!link.lineWorking[i] && !link.lineLatchStrobe[i]) begin
						next_st[i] = DLT_H_IDLE;
					end
				end
				default: next_st[i] = DLT_H_IDLE;
			endcase
			// R14: data and judgement latched together on gate fall
			if (gatePrev[i] && !link.lineLatchStrobe[i]) begin
				next_dat[i*8 +: 8] = link.lineResultBits[i*8 +: 8];
				next_jud[i] = link.lineJudgement[i];
				next_val[i] = 1'b1;
			end
			next_fb[i] = (next_st[i] != DLT_H_IDLE);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st <= '{default: DLT_H_IDLE};
			cnt <= '{default: '0};
			trig <= 2'h0;
			fb <= 2'h0;
			jud <= 2'h0;
			val <= 2'h0;
			dat <= 16'h0000;
			gatePrev <= 2'h0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			trig <= next_trig;
			fb <= next_fb;
			jud <= next_jud;
			val <= next_val;
			dat <= next_dat;
			gatePrev <= link.lineLatchStrobe;
		end
	end
endmodule

//--- test/dlt_handshake_checker.sv
// Purpose: Assertions on the parallel lines
// Assumes: GATE 5, MEAS 40, FILTER 4 as set by the bench
// Notes: Line 1 busy width varies with capture stall
`timescale 1ns/1ps
module dlt_handshake_checker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic dualLineMode,
	input wire logic liveView,
	input wire logic [1:0] lineTrigger,
	input wire logic [1:0] lineAcceptOk,
	input wire logic [1:0] lineWorking,
	input wire logic [1:0] lineJudgement,
	input wire logic [15:0] lineResultBits,
	input wire logic [1:0] lineLatchStrobe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_busy_blocks_ready: assert property (lineWorking[0] |-> !lineAcceptOk[0])
		else $error("ready high while busy");
	a_idle_ready_up: assert property ($past(nrst) && !lineWorking[0] && !liveView &&
		!$past(liveView) |-> lineAcceptOk[0]) else $error("idle line not ready");
	a_live_ready_low: assert property (liveView && $past(liveView) |-> lineAcceptOk == 2'b00)
		else $error("ready high in live view");
	a_busy_length: assert property ($rose(lineWorking[0]) |-> ##[39:41] $fell(lineWorking[0]))
		else $error("busy width wrong");
	a_line1_run: assert property ($past(nrst) && !dualLineMode |-> lineWorking[1])
		else $error("line 1 busy not run");
	a_data_at_fall: assert property ($changed(lineResultBits[7:0]) |-> $fell(lineWorking[0]))
		else $error("data 0 changed off busy fall");
	a_data1_at_fall: assert property ($changed(lineResultBits[15:8]) |-> $fell(lineWorking[1]))
		else $error("data 1 changed off busy fall");
	a_judge_at_fall: assert property ($changed(lineJudgement[0]) |-> $fell(lineWorking[0]))
		else $error("judgement changed off busy fall");
	a_gate_width: assert property ($rose(lineLatchStrobe[0]) |->
		lineLatchStrobe[0] [*5] ##1 !lineLatchStrobe[0]) else $error("gate width wrong");
	a_gate_in_busy: assert property ($rose(lineLatchStrobe[0]) |-> lineWorking[0])
		else $error("gate outside busy");
	a_trig_filtered: assert property ($rose(lineWorking[0]) |->
		lineTrigger[0] && $past(lineTrigger[0], 4)) else $error("trigger not filtered");
	c_line0_latch_strobe: cover property ($rose(lineLatchStrobe[0]));
	c_line1_latch_strobe: cover property ($rose(lineLatchStrobe[1]));
	c_both_busy: cover property (lineWorking == 2'b11 && dualLineMode);
endmodule

//--- test/dual_line_trigger_handshake_tb.sv
// Purpose: Both ends joined; table of trigger runs
// Assumes: FILTER 4, HOLD 20, GATE 5, MEAS 40, CAPTURE 8
// Notes: Each run resets with its own settings, fires twice
`timescale 1ns/1ps
module dual_line_trigger_handshake_tb;
	logic sys_clk = 0, nrst = 0, dualLineMode = 0, liveView = 0, judgeOnFail = 0;
	logic outputStepPresent = 0, runIndication;
	logic [1:0] lineFail = 0, fireReq = 0, fireBusy, latchedJudgement, latchedValid, prevGate = 0;
	logic [15:0] resultIn = 0, latchedData;
	int num_errors = 0, num_checks = 0, gates0 = 0, gates1 = 0, valids = 0;
	always #50 sys_clk = ~sys_clk;
	dlt_if link();
	dlt_device #(.FILTER_CYC(4), .GATE_CYC(5), .MEAS_CYC(40),
		.CAPTURE_CYC(8)) dlt_device_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link),
		.dualLineMode(dualLineMode), .liveView(liveView), .judgeOnFail(judgeOnFail),
		.outputStepPresent(outputStepPresent), .lineFail(lineFail), .resultIn(resultIn),
		.runIndication(runIndication));
	dlt_host #(.HOLD_CYC(20)) dlt_host_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link),
		.fireReq(fireReq), .fireBusy(fireBusy), .latchedData(latchedData),
		.latchedJudgement(latchedJudgement), .latchedValid(latchedValid));
	dlt_handshake_checker dlt_handshake_checker_inst (.sys_clk(sys_clk), .nrst(nrst),
		.dualLineMode(dualLineMode), .liveView(liveView), .lineTrigger(link.lineTrigger),
		.lineAcceptOk(link.lineAcceptOk), .lineWorking(link.lineWorking),
		.lineJudgement(link.lineJudgement), .lineResultBits(link.lineResultBits),
		.lineLatchStrobe(link.lineLatchStrobe));
	always @(posedge sys_clk) begin
		prevGate <= link.lineLatchStrobe;
		gates0 <= gates0 + int'(link.lineLatchStrobe[0] & ~prevGate[0]);
		gates1 <= gates1 + int'(link.lineLatchStrobe[1] & ~prevGate[1]);
		valids <= valids + int'(latchedValid[0]) + int'(latchedValid[1]);
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic fire(input logic [1:0] lines);
		int n;
		@(negedge sys_clk) fireReq = lines;
		@(negedge sys_clk) fireReq = 2'b00;
		for (n = 0; n < 600 && (fireBusy & lines) !== 2'b00; n++) @(negedge sys_clk);
		if (n == 600) begin
			num_errors++;
			$display("[ERR] %0t host cycle hung", $time);
			print_verdict();
		end
	endtask
	// Settings: dual, live, fail polarity, output step, compare outputs
	task automatic run(input logic [1:0] lines, input logic [4:0] cfg, input logic [1:0] fail,
		input logic [15:0] data, input logic [1:0] expJ, input logic [15:0] expD,
		input logic [1:0] expG);
		int g0, g1, v0;
		@(negedge sys_clk) nrst = 0;
		{dualLineMode, liveView, judgeOnFail, outputStepPresent} = cfg[4:1];
		lineFail = fail;
		resultIn = data;
		repeat (3) @(negedge sys_clk);
		nrst = 1;
		g0 = gates0;
		g1 = gates1;
		v0 = valids;
		fire(lines);
		fire(lines);
		repeat (10) @(negedge sys_clk);
		check(16'(gates0 - g0), {14'h0, expG[0], 1'b0}, "gates line 0");
		check(16'(gates1 - g1), {14'h0, expG[1], 1'b0}, "gates line 1");
		check(16'(valids - v0), {13'h0, expG[0] & expG[1], expG[0] ^ expG[1], 1'b0},
			"latch pulses");
		check({14'h0, link.lineAcceptOk}, {14'h0, liveView ? 2'b00 : {dualLineMode, 1'b1}},
			"ready");
		check({15'h0, link.lineWorking[1]}, {15'h0, ~dualLineMode}, "line 1 busy");
		check({15'h0, runIndication}, 16'h0001, "run");
		if (cfg[0]) begin
			check({14'h0, link.lineJudgement}, {14'h0, expJ}, "judgement");
			check(link.lineResultBits, expD, "data");
			// Second strobe latches the first result
			check(latchedData, expD, "latched data");
			check({14'h0, latchedJudgement}, {14'h0, expJ}, "latched judgement");
		end
		$display("test lines %b cfg %b done", lines, cfg);
	endtask
	initial begin
		run(2'b11, 5'b10011, 2'b01, 16'hA55A, 2'b10, 16'hA55A, 2'b11);
		run(2'b01, 5'b10111, 2'b01, 16'h3C7E, 2'b01, 16'h007E, 2'b01);
		run(2'b01, 5'b10000, 2'b00, 16'h1234, 2'b00, 16'h0000, 2'b00);
		run(2'b01, 5'b11011, 2'b00, 16'h0011, 2'b01, 16'h0011, 2'b01);
		run(2'b01, 5'b00011, 2'b10, 16'hFF22, 2'b01, 16'h0022, 2'b01);
		print_verdict();
	end
endmodule
